// [include/sbx_map.svh]
`ifndef SBX_MAP_SVH
`define SBX_MAP_SVH
`define SBX_DATA_W 8
`define SBX_ONES 8'hFF
`define SBX_ONE 8'h01
`define SBX_ZERO 8'h00
`define SBX_FLAG_C 0
`define SBX_FLAG_AC 1
`define SBX_FLAG_Z 2
`define SBX_FLAG_OV 3
`define SBX_SKIP_CYCLES 2
`define SBX_PLAIN_CYCLES 1
`endif

// [include/sbx_pkg.sv]
package sbx_pkg;
    typedef enum logic [2:0] {
        SBX_OP_NONE,
        SBX_OP_BORROW_SUB_MEM,
        SBX_OP_DEC_SKIP_MEM,
        SBX_OP_DEC_SKIP_WORK,
        SBX_OP_INC_SKIP_WORK,
        SBX_OP_SET_BYTE,
        SBX_OP_SET_BIT
    } sbx_op_t;
endpackage : sbx_pkg

// [rtl/sbx_alu.sv]
`timescale 1ns/1ps
`include "sbx_map.svh"
module sbx_alu
    import sbx_pkg::*;
(
    // operands
    input wire sbx_op_t op_in,
    input wire logic [7:0] work_in,
    input wire logic [7:0] mem_in,
    input wire logic carry_in,
    input wire logic [2:0] bit_sel_in,
    // results
    output logic [7:0] result_out,
    output logic to_mem_out,
    output logic to_work_out,
    output logic skip_out,
    output logic flags_upd_out,
    output logic [3:0] flags_out
);
    logic [8:0] sum;
    logic [4:0] low_sum;
    logic [7:0] inv_m;

    always_comb begin
        inv_m = ~mem_in;
        sum = {1'b0, work_in} + {1'b0, inv_m} + {8'h00, carry_in};
        low_sum = {1'b0, work_in[3:0]} + {1'b0, inv_m[3:0]} + {4'h0, carry_in};
        result_out = `SBX_ZERO;
        to_mem_out = 1'b0;
        to_work_out = 1'b0;
        skip_out = 1'b0;
        flags_upd_out = 1'b0;
        flags_out = 4'h0;
        unique case (op_in)
            SBX_OP_NONE: begin
            end
            SBX_OP_BORROW_SUB_MEM: begin
                result_out = sum[7:0]; // RL1
                to_mem_out = 1'b1;
                flags_upd_out = 1'b1;
                flags_out[`SBX_FLAG_C] = sum[8];
                flags_out[`SBX_FLAG_AC] = low_sum[4];
                flags_out[`SBX_FLAG_Z] = (sum[7:0] == `SBX_ZERO);
                flags_out[`SBX_FLAG_OV] = (work_in[7] == inv_m[7]) && (sum[7] != work_in[7]);
            end
            SBX_OP_DEC_SKIP_MEM: begin
                result_out = mem_in - `SBX_ONE; // RL2
                to_mem_out = 1'b1;
                skip_out = (result_out == `SBX_ZERO); // RL3
            end
            SBX_OP_DEC_SKIP_WORK: begin
                result_out = mem_in - `SBX_ONE; // RL6
                to_work_out = 1'b1;
                skip_out = (result_out == `SBX_ZERO);
            end
            SBX_OP_INC_SKIP_WORK: begin
                result_out = mem_in + `SBX_ONE; // RL7
                to_work_out = 1'b1;
                skip_out = (result_out == `SBX_ZERO);
            end
            SBX_OP_SET_BYTE: begin
                result_out = `SBX_ONES; // RL8
                to_mem_out = 1'b1;
            end
            SBX_OP_SET_BIT: begin
                result_out = mem_in | (`SBX_ONE << bit_sel_in); // RL8
                to_mem_out = 1'b1;
            end
            default: begin
            end
        endcase
    end
endmodule : sbx_alu

// [rtl/sbx_exec_unit.sv]
`timescale 1ns/1ps
`include "sbx_map.svh"
// Contract
// [RL1] borrow subtract: work + ~mem + carry into memory, OV Z AC C updated
// [RL2] decrement-skip-mem: memory byte minus one written back to it
// [RL3] zero result skips next instruction by discarding the prefetch
// [RL4] taken skip adds one dummy cycle, two cycles total
// [RL5] no skip: instruction completes in one cycle
// [RL6] decrement-skip-work: mem minus one to work register, memory unchanged, skips on zero
// [RL7] increment-skip-work: mem plus one to work register, skips on zero
// [RL8] set byte writes ones, set bit forces one bit, flags untouched
module sbx_exec_unit
    import sbx_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rstn_in,
    // instruction issue
    input wire logic issue_in,
    input wire sbx_op_t op_in,
    input wire logic [2:0] bit_sel_in,
    input wire logic [7:0] mem_rd_in,
    input wire logic [7:0] work_in,
    input wire logic [3:0] flags_in,
    // results
    output logic mem_we_out,
    output logic [7:0] mem_wd_out,
    output logic work_we_out,
    output logic [7:0] work_wd_out,
    output logic flags_we_out,
    output logic [3:0] flags_out,
    // sequencing
    output logic discard_out,
    output logic busy_out,
    output logic done_out
);
    // alu results for the operand presented this cycle
    logic [7:0] res;
    logic to_mem;
    logic to_work;
    logic skip;
    logic fupd;
    logic [3:0] fl;

    // a taken skip parks the sequencer in the dummy state for one cycle
    typedef enum logic {
        SBX_SEQ_RUN,
        SBX_SEQ_DUMMY
    } sbx_seq_t;

    // issue gating and sequencer state
    sbx_seq_t seq_ff;
    sbx_seq_t nxt_seq;
    logic take;
    logic skip_hit;

    // next values of the output flops
    logic nxt_mem_we;
    logic [7:0] nxt_mem_wd;
    logic nxt_work_we;
    logic [7:0] nxt_work_wd;
    logic nxt_flags_we;
    logic [3:0] nxt_flags;
    logic nxt_discard;
    logic nxt_busy;
    logic nxt_done;

    // the dummy state both gates issue and completes the skipping instruction
    function automatic logic in_dummy(input sbx_seq_t s);
        return s == SBX_SEQ_DUMMY;
    endfunction : in_dummy

    sbx_alu u_alu (
        // operands
        .op_in(op_in),
        .work_in(work_in),
        .mem_in(mem_rd_in),
        .carry_in(flags_in[`SBX_FLAG_C]),
        .bit_sel_in(bit_sel_in),
        // results
        .result_out(res),
        .to_mem_out(to_mem),
        .to_work_out(to_work),
        .skip_out(skip),
        .flags_upd_out(fupd),
        .flags_out(fl)
    );

    // issue is refused during the dummy cycle and busy_out reports it,
    // so the fetch stage can hold off
    always_comb begin
        take = issue_in && !in_dummy(seq_ff);
        skip_hit = take && skip; // RL3
    end

    // a dummy cycle never chains: the refused issue in it cannot skip again
    always_comb begin
        nxt_seq = SBX_SEQ_RUN;
        unique case (seq_ff)
            SBX_SEQ_RUN: begin
                if (skip_hit) begin
                    nxt_seq = SBX_SEQ_DUMMY; // RL4
                end
            end
            SBX_SEQ_DUMMY: begin
                nxt_seq = SBX_SEQ_RUN;
            end
        endcase
    end

    // reset returns to run so the first issue after release is taken at once
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            seq_ff <= SBX_SEQ_RUN;
        end else begin
            seq_ff <= nxt_seq;
        end
    end

    // memory write-back; the data word holds until the next take
    always_comb begin
        nxt_mem_we = take && to_mem; // RL2
        nxt_mem_wd = mem_wd_out;
        if (take) begin
            nxt_mem_wd = res; // RL8
        end
    end

    // the strobe lasts one cycle, so memory sees each write exactly once
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mem_we_out <= 1'b0;
            mem_wd_out <= `SBX_ZERO;
        end else begin
            mem_we_out <= nxt_mem_we;
            mem_wd_out <= nxt_mem_wd;
        end
    end

    // work register write-back; these forms leave memory unaltered
    always_comb begin
        nxt_work_we = take && to_work; // RL6
        nxt_work_wd = work_wd_out;
        if (take) begin
            nxt_work_wd = res; // RL7
        end
    end

    // the work strobe also lasts one cycle; its data word holds like the memory one
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            work_we_out <= 1'b0;
            work_wd_out <= `SBX_ZERO;
        end else begin
            work_we_out <= nxt_work_we;
            work_wd_out <= nxt_work_wd;
        end
    end

    // status flags: only the borrow subtract loads them, skips and sets never do
    always_comb begin
        nxt_flags_we = take && fupd; // RL1
    end

    // one select per status bit; an unloaded bit keeps its last value
    for (genvar i = 0; i < 4; i = i + 1) begin : g_flag
        assign nxt_flags[i] = nxt_flags_we ? fl[i] : flags_out[i]; // RL8
    end

    // the load strobe pulses with the new value so the core copies all four together
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            flags_we_out <= 1'b0;
            flags_out <= 4'h0;
        end else begin
            flags_we_out <= nxt_flags_we;
            flags_out <= nxt_flags; // RL1
        end
    end

    // the dummy cycle replaces the discarded prefetch
    always_comb begin
        nxt_discard = skip_hit; // RL3
    end

    // discard is a one-cycle pulse: the prefetch stage drops exactly one word
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            discard_out <= 1'b0;
        end else begin
            discard_out <= nxt_discard;
        end
    end

    // busy marks the dummy cycle, so the fetch stage knows to hold off
    always_comb begin
        nxt_busy = skip_hit; // RL4
    end

    // reset clears busy so no false dummy cycle follows reset
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            busy_out <= 1'b0;
        end else begin
            busy_out <= nxt_busy;
        end
    end

    // completion: a plain instruction finishes at once, a skip after its dummy cycle
    always_comb begin
        nxt_done = (take && !skip) || in_dummy(seq_ff); // RL5
    end

    // done follows the dummy state, not the refused issue inside it
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            done_out <= 1'b0;
        end else begin
            done_out <= nxt_done;
        end
    end
endmodule : sbx_exec_unit

// [bench/sbx_exec_monitor.sv]
`timescale 1ns/1ps
module sbx_exec_monitor
    import sbx_pkg::*;
(
    input wire logic mclk_in, rstn_in, issue_in, busy_out, done_out, discard_out,
    input wire logic flags_we_out,
    input wire sbx_op_t op_in,
    input wire logic [2:0] bit_sel_in,
    input wire logic [3:0] flags_in,
    input wire logic [7:0] mem_rd_in, work_in, mem_wd_out, work_wd_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    wire tk = issue_in && !busy_out;
    wire [7:0] m = mem_rd_in;
    wire hit = tk && (op_in == SBX_OP_INC_SKIP_WORK ? m == 8'hFF
        : m == 8'h01 && op_in inside {SBX_OP_DEC_SKIP_MEM, SBX_OP_DEC_SKIP_WORK});
    a_sub_sum: assert property (tk && op_in == SBX_OP_BORROW_SUB_MEM |=>
        mem_wd_out == $past(work_in + ~m + flags_in[0])) else $error("sub");
    a_dec_mem: assert property (tk && op_in == SBX_OP_DEC_SKIP_MEM |=>
        mem_wd_out == $past(m) - 8'h01) else $error("dec");
    a_skip_drop: assert property (hit |=> discard_out) else $error("drop");
    a_skip_two: assert property (hit |=> busy_out ##1 done_out) else $error("two");
    a_plain_one: assert property (tk && !hit |=> done_out) else $error("one");
    a_dec_work: assert property (tk && op_in == SBX_OP_DEC_SKIP_WORK |=>
        work_wd_out == $past(m) - 8'h01) else $error("decw");
    a_inc_work: assert property (tk && op_in == SBX_OP_INC_SKIP_WORK |=>
        work_wd_out == $past(m) + 8'h01) else $error("inc");
    a_set_bit: assert property (tk && op_in == SBX_OP_SET_BIT |=> !flags_we_out &&
        mem_wd_out == ($past(m) | 8'h01 << $past(bit_sel_in))) else $error("set");
endmodule : sbx_exec_monitor

// [bench/sbx_exec_unit_tb.sv]
`timescale 1ns/1ps
module sbx_exec_unit_tb;
    import sbx_pkg::*;
    logic mclk_in = 1'h0, rstn_in = 1'h0, issue_in = 1'h0;
    logic mem_we_out, work_we_out, flags_we_out, discard_out, busy_out, done_out;
    sbx_op_t op_in = SBX_OP_NONE;
    logic [2:0] bit_sel_in = 3'h7;
    logic [3:0] flags_in = 4'h1, flags_out;
    logic [7:0] mem_rd_in = 8'h00, work_in = 8'h05, mem_wd_out, work_wd_out;
    int n_mismatch = 0, compares = 0;
    sbx_exec_unit sbx_exec_unit_inst (
        .mclk_in(mclk_in), .rstn_in(rstn_in), .issue_in(issue_in), .op_in(op_in),
        .bit_sel_in(bit_sel_in), .mem_rd_in(mem_rd_in), .work_in(work_in),
        .flags_in(flags_in), .mem_we_out(mem_we_out), .mem_wd_out(mem_wd_out),
        .work_we_out(work_we_out), .work_wd_out(work_wd_out),
        .flags_we_out(flags_we_out), .flags_out(flags_out),
        .discard_out(discard_out), .busy_out(busy_out), .done_out(done_out)
    );
    task chk(input logic [11:0] s, e);
        compares++;
        n_mismatch += int'(s !== e);
        if (s !== e) $display("wrong value %0t %h %h", $time, s, e);
    endtask : chk
    task iss(input sbx_op_t o, input logic [7:0] v);
        op_in = o;
        mem_rd_in = v;
        issue_in = 1'h1;
        @(posedge mclk_in) #1;
    endtask : iss
    // issue stays high through the dummy cycle: it must be refused
    task t_mem;
        iss(SBX_OP_BORROW_SUB_MEM, 8'h05);
        chk({mem_wd_out, flags_out}, 12'h007);
        chk(flags_we_out, 12'h001);
        iss(SBX_OP_DEC_SKIP_MEM, 8'h01);
        chk({mem_wd_out, discard_out, busy_out, mem_we_out}, 12'h007);
        @(posedge mclk_in) #1;
        chk({done_out, mem_we_out}, 12'h002);
        issue_in = 1'h0;
        @(posedge mclk_in) #1;
        iss(SBX_OP_SET_BIT, 8'h12);
        chk({mem_wd_out, flags_we_out}, 12'h124);
    endtask : t_mem
    task t_work;
        iss(SBX_OP_DEC_SKIP_WORK, 8'h00);
        chk({work_wd_out, discard_out, done_out}, 12'h3FD);
        iss(SBX_OP_INC_SKIP_WORK, 8'hFF);
        chk({work_wd_out, work_we_out, discard_out}, 12'h003);
        issue_in = 1'h0;
        @(posedge mclk_in) #1;
        chk({busy_out, done_out}, 12'h001);
        iss(SBX_OP_SET_BYTE, 8'h12);
        chk({mem_wd_out, mem_we_out, flags_we_out}, 12'h3FE);
        iss(SBX_OP_NONE, 8'h00);
        chk({done_out, mem_we_out, work_we_out, flags_we_out}, 12'h008);
        issue_in = 1'h0;
    endtask : t_work
    // reset in mid-skip clears every strobe and the pending dummy cycle
    task t_reset;
        iss(SBX_OP_DEC_SKIP_MEM, 8'h01);
        issue_in = 1'h0;
        rstn_in = 1'h0;
        #1;
        chk({mem_we_out, work_we_out, flags_we_out, discard_out, busy_out, done_out},
            12'h000);
        @(posedge mclk_in) #1;
        rstn_in = 1'h1;
        @(posedge mclk_in) #1;
        chk({done_out, busy_out, discard_out}, 12'h000);
    endtask : t_reset
    task results;
        if (n_mismatch == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    initial forever #20 mclk_in = ~mclk_in;
    initial begin
        repeat (6) @(posedge mclk_in);
        #1 rstn_in = 1'h1;
        t_mem;
        t_reset;
        t_work;
        results;
    end
endmodule : sbx_exec_unit_tb
bind sbx_exec_unit sbx_exec_monitor sbx_exec_monitor_inst (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .issue_in(issue_in), .busy_out(busy_out),
    .done_out(done_out), .discard_out(discard_out), .flags_we_out(flags_we_out),
    .op_in(op_in), .bit_sel_in(bit_sel_in), .flags_in(flags_in), .mem_rd_in(mem_rd_in),
    .work_in(work_in), .mem_wd_out(mem_wd_out), .work_wd_out(work_wd_out)
);
